// File: dv/cvlim_host_model.sv
// partner: bus host issuing one-cycle command pulses
`timescale 1ns/1ps
module cvlim_host_model (
    // clock
    input  wire logic            clk_in,
    // command and answer
    output cvlim_pkg::cvlim_cmd_t cmd_out,
    input  wire logic            nack_in,
    input  wire logic [15:0]     read_data_in
);
    import cvlim_pkg::*;
    // idle bus shows an inverted pattern, never a stale copy
    initial cmd_out = '{1'b0, 1'b0, 8'hFF, 16'hFFFF};
    // one request; the answer is gathered over the next two cycles
    task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] data,
                          input int gap, output logic nack, output logic [15:0] rd);
        repeat (gap) @(negedge clk_in);
        @(negedge clk_in);
        cmd_out = '{wr, !wr, code, data};
        @(negedge clk_in);
        cmd_out = '{1'b0, 1'b0, ~code, ~data};
        nack = nack_in;
        @(negedge clk_in);
        nack = nack | nack_in;
        rd = read_data_in;
    endtask : access
endmodule : cvlim_host_model

// File: dv/cvlim_regs_properties.sv
// checker: port timing relations of the limit/option bank
`timescale 1ns/1ps
module cvlim_regs_properties (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    // command side
    input  wire logic             loop_follower_in,
    input  cvlim_pkg::cvlim_cmd_t  cmd_in,
    input  wire logic             cmd_nack_out,
    input  wire logic             invalid_command_fault_out,
    input  wire logic             alert_out,
    input  wire logic             nvm_store_strobe_out,
    input  wire logic [15:0]      nvm_store_data_out,
    // monitoring and pins
    input  wire logic [7:0]       feedback_node_in,
    input  cvlim_pkg::cvlim_tele_t readback_out,
    input  wire logic             monitor_converter_run_out,
    input  wire logic             negative_limit_disable_out,
    input  wire logic             power_good_out,
    input  wire logic             shared_reset_good_pin_n_out
);
    import cvlim_pkg::*;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    // decoded requests
    logic fol_hit;
    logic opt_wr;
    assign fol_hit = (cmd_in.write || cmd_in.read) && loop_follower_in
                     && cmd_in.code == CVLIM_CMD_PCT_SELECT;
    assign opt_wr = cmd_in.write && cmd_in.code == CVLIM_CMD_OPTIONS;
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_follower_refused: assert property (fol_hit |=> cmd_nack_out)
        else $error("follower access to select not refused");
    a_follower_flags: assert property (fol_hit |=> invalid_command_fault_out && alert_out)
        else $error("follower access raised no fault");
    a_store_pulse: assert property (cmd_in.write && cmd_in.code == CVLIM_CMD_STORE_ALL
        |=> nvm_store_strobe_out)
        else $error("store command gave no strobe");
    a_store_volatile: assert property (nvm_store_strobe_out |-> nvm_store_data_out[4:3] == 2'h0)
        else $error("volatile option bit stored");
    a_neg_limit: assert property (opt_wr |-> ##2 negative_limit_disable_out
        == $past(cmd_in.data[CVLIM_OPT_NEG_LIMIT_DIS], 2))
        else $error("negative limit output off its bit");
    a_run_enable: assert property (opt_wr |-> ##2 monitor_converter_run_out
        == $past(cmd_in.data[CVLIM_OPT_MON_ENABLE], 2))
        else $error("monitor run output off its bit");
    a_pg_over: assert property (feedback_node_in > 8'd112 |=> !power_good_out)
        else $error("power good kept above warn level");
    a_pg_under: assert property (feedback_node_in < 8'd64 |=> !power_good_out)
        else $error("power good kept below warn level");
    a_pg_release: assert property ($rose(power_good_out) |-> $past(feedback_node_in) > 8'd95)
        else $error("power good restored too low");
    a_readback_frozen: assert property (!monitor_converter_run_out [*2] |=> $stable(readback_out))
        else $error("readback moved while converter off");
    a_pin_tracks: assert property (shared_reset_good_pin_n_out == power_good_out)
        else $error("shared pin differs from power good");
    // main scenarios reached
    c_refused: cover property (fol_hit);
    c_stored: cover property (nvm_store_strobe_out);
    c_pg_drop: cover property ($fell(power_good_out));
endmodule : cvlim_regs_properties

bind cvlim_regs cvlim_regs_properties i_props (.*);

// File: dv/testbench.sv
// testbench: self-checking run of the limit/option bank
`timescale 1ns/1ps
module testbench;
    import cvlim_pkg::*;
    // ----------------------------------------
    // signals and stimulus tables
    // ----------------------------------------
    logic        clk_in, reset_in, loop_follower_in, nvm_valid_in, sample_valid_in;
    logic        cmd_checked_in, cmd_data_bad_in, cmd_nack_out, alert_out, h_nack;
    logic        invalid_command_fault_out, invalid_value_flag_out, power_good_out;
    logic        monitor_converter_run_out, negative_limit_disable_out;
    logic        shared_reset_good_pin_n_out, nvm_store_strobe_out, sample_tick_out;
    logic [15:0] nvm_options_in, read_data_out, nvm_store_data_out, h_rd, st_data;
    logic [7:0]  feedback_node_in;
    logic [3:0]  flag_out;
    cvlim_cmd_t  cmd_in;
    cvlim_tele_t sample_in, readback_out;
    int          mismatches, checks_done, st_cnt;
    localparam cvlim_thresh_t TH [4] = '{'{8'd83, 8'd88, 8'd112, 8'd117},
        '{8'd88, 8'd90, 8'd110, 8'd112}, '{8'd72, 8'd78, 8'd112, 8'd117},
        '{8'd58, 8'd64, 8'd112, 8'd117}};
    localparam cvlim_tele_t S1 = '{16'h1111, 16'h2222, 16'h3333};
    localparam cvlim_tele_t S2 = '{16'h4444, 16'h5555, 16'h6666};
    localparam cvlim_tele_t S3 = '{16'h7777, 16'h8888, 16'h9999};
    localparam cvlim_tele_t S3X = '{16'h7777, 16'h2222, 16'h3333};

    always #12.5 clk_in = ~clk_in;
    // count strobes off the edge
    always @(negedge clk_in) begin
        if (nvm_store_strobe_out) begin
            st_cnt++;
            st_data = nvm_store_data_out;
        end
    end

    cvlim_host_model i_host (.clk_in(clk_in), .cmd_out(cmd_in), .nack_in(cmd_nack_out),
        .read_data_in(read_data_out));
    cvlim_regs i_dut (.*);
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic acc(input logic wr, input logic [7:0] code, input logic [15:0] data);
        i_host.access(wr, code, data, 0, h_nack, h_rd);
        @(negedge clk_in);
    endtask : acc
    task automatic do_reset();
        @(negedge clk_in);
        reset_in = 1'b1;
        repeat (10) @(negedge clk_in);
        reset_in = 1'b0;
    endtask : do_reset
    task automatic step(input logic [7:0] fb, input logic pg, input logic [3:0] fl);
        @(negedge clk_in);
        feedback_node_in = fb;
        repeat (2) @(negedge clk_in);
        chk("power_good", 48'(pg), 48'(power_good_out));
        chk("pin", 48'(pg), 48'(shared_reset_good_pin_n_out));
        chk("flags", 48'(fl), 48'(flag_out));
    endtask : step
    // equal samples so averaging is exact
    task automatic feed(input cvlim_tele_t s, input cvlim_tele_t exp, input bit stop);
        for (int k = 0; k < 40 && !(stop && readback_out === exp); k++) begin
            sample_in = s;
            sample_valid_in = 1'b1;
            @(negedge clk_in);
            sample_valid_in = 1'b0;
            repeat (3) @(negedge clk_in);
        end
        chk("readback", exp, readback_out);
        if (stop && readback_out !== exp) summarize();
    endtask : feed
    task automatic bad_write();
        {cmd_checked_in, cmd_data_bad_in} = 2'b11;
        acc(1'b1, 8'h21, 16'hFFFF);
        {cmd_checked_in, cmd_data_bad_in} = 2'b00;
    endtask : bad_write
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        acc(1'b0, CVLIM_CMD_PCT_SELECT, 16'h0);
        chk("select", 48'h0, 48'(h_rd));
        acc(1'b0, CVLIM_CMD_OPTIONS, 16'h0);
        chk("options", 48'h0084, 48'(h_rd));
        chk("run", 48'h1, 48'(monitor_converter_run_out));
        st_cnt = 0;
        repeat (400) @(negedge clk_in) st_cnt += sample_tick_out;
        chk("ticks", 48'h1, 48'(st_cnt));
        $display("test reset done");
    endtask : t_reset
    task automatic t_thresh();
        cvlim_thresh_t t;
        for (int c = 0; c < 4; c++) begin
            acc(1'b1, CVLIM_CMD_PCT_SELECT, 16'(c));
            t = TH[c];
            step(8'd100, 1'b1, 4'h0);
            step(t.ov_warn, 1'b1, 4'h0);
            step(t.ov_warn + 8'd1, 1'b0, 4'h4);
            step(t.ov_fault + 8'd1, 1'b0, 4'hC);
            step(8'd105, 1'b0, 4'h0);
            step(8'd104, 1'b1, 4'h0);
            step(t.uv_warn - 8'd1, 1'b0, 4'h2);
            step(t.uv_fault - 8'd1, 1'b0, 4'h3);
            step(8'd95, 1'b0, 4'h0);
            step(8'd96, 1'b1, 4'h0);
        end
        $display("test thresholds done");
    endtask : t_thresh
    task automatic t_opts();
        feed(S1, S1, 1'b1);
        acc(1'b1, CVLIM_CMD_OPTIONS, 16'h0003);
        chk("neg_limit", 48'h1, 48'(negative_limit_disable_out));
        chk("run", 48'h0, 48'(monitor_converter_run_out));
        chk("pin", 48'h1, 48'(shared_reset_good_pin_n_out));
        feed(S2, S1, 1'b0);
        acc(1'b1, CVLIM_CMD_OPTIONS, 16'h000C);
        feed(S3, S3X, 1'b1);
        acc(1'b1, CVLIM_CMD_OPTIONS, 16'h7FFF);
        st_cnt = 0;
        acc(1'b1, CVLIM_CMD_STORE_ALL, 16'h0);
        chk("store_count", 48'h1, 48'(st_cnt));
        chk("store_data", 48'h7FE7, 48'(st_data));
        acc(1'b1, CVLIM_CMD_OPTIONS, 16'h0084);
        chk("neg_limit", 48'h0, 48'(negative_limit_disable_out));
        $display("test options done");
    endtask : t_opts
    task automatic t_override();
        acc(1'b1, CVLIM_CMD_OPTIONS, 16'h0094);
        bad_write();
        chk("invalid", 48'h0, 48'(invalid_value_flag_out));
        chk("alert", 48'h0, 48'(alert_out));
        acc(1'b1, CVLIM_CMD_OPTIONS, 16'h0084);
        repeat (4) @(negedge clk_in);
        chk("alert", 48'h0, 48'(alert_out));
        bad_write();
        chk("invalid", 48'h1, 48'(invalid_value_flag_out));
        $display("test override done");
    endtask : t_override
    task automatic t_follower();
        do_reset();
        loop_follower_in = 1'b1;
        acc(1'b1, CVLIM_CMD_PCT_SELECT, 16'h0002);
        chk("nack", 48'h1, 48'(h_nack));
        chk("fault", 48'h1, 48'(invalid_command_fault_out));
        chk("alert", 48'h1, 48'(alert_out));
        acc(1'b0, CVLIM_CMD_PCT_SELECT, 16'h0);
        chk("nack", 48'h1, 48'(h_nack));
        loop_follower_in = 1'b0;
        acc(1'b0, CVLIM_CMD_PCT_SELECT, 16'h0);
        chk("select", 48'h0, 48'(h_rd));
        $display("test follower done");
    endtask : t_follower
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {clk_in, loop_follower_in, nvm_valid_in, sample_valid_in} = 4'h0;
        {cmd_checked_in, cmd_data_bad_in, mismatches, checks_done, st_cnt} = '0;
        reset_in = 1'b1;
        nvm_options_in = 16'h0000;
        feedback_node_in = 8'd100;
        sample_in = '0;
        do_reset();
        t_reset();
        t_thresh();
        t_opts();
        t_override();
        t_follower();
        summarize();
    end
endmodule : testbench

// File: verilog/cvlim_pkg.sv
// package: offsets, field positions, reset values and timing counts for the limit/option bank
package cvlim_pkg;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CVLIM_CMD_PCT_SELECT  = 8'hD7;
    localparam logic [7:0] CVLIM_CMD_OPTIONS     = 8'hE5;
    localparam logic [7:0] CVLIM_CMD_STORE_ALL   = 8'h11;

    // ------------------------------------------------------------
    // field positions of the options word
    // ------------------------------------------------------------
    localparam int CVLIM_OPT_NEG_LIMIT_DIS = 0;
    localparam int CVLIM_OPT_RESET_FUNC    = 1;
    localparam int CVLIM_OPT_MON_ENABLE    = 2;
    localparam int CVLIM_OPT_FAST_MEASURE  = 3;
    localparam int CVLIM_OPT_LIMIT_OVR     = 4;

    // ------------------------------------------------------------
    // reset values and write masks
    // ------------------------------------------------------------
    localparam logic [7:0]  CVLIM_PCT_RESET     = 8'h00;
    localparam logic [7:0]  CVLIM_PCT_WMASK     = 8'h03;
    localparam logic [15:0] CVLIM_OPT_RESET     = 16'h0084;
    localparam logic [15:0] CVLIM_OPT_WMASK     = 16'h7FFF;
    // fast-measure and limit-override bits are never stored
    localparam logic [15:0] CVLIM_OPT_NVM_MASK  = 16'h7FE7;

    // ------------------------------------------------------------
    // thresholds in units of 1% of reference
    // ------------------------------------------------------------
    localparam logic [7:0] CVLIM_PG_OV_RELEASE = 8'd105;
    localparam logic [7:0] CVLIM_PG_UV_RELEASE = 8'd95;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CVLIM_CLK_HZ        = 40_000_000;
    localparam int CVLIM_SAMPLE_US     = 10;
    localparam int CVLIM_SAMPLE_CYC    = CVLIM_CLK_HZ / 1_000_000 * CVLIM_SAMPLE_US;
    localparam int CVLIM_AVG_COUNT     = 8;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] uv_fault;
        logic [7:0] uv_warn;
        logic [7:0] ov_warn;
        logic [7:0] ov_fault;
    } cvlim_thresh_t;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] code;
        logic [15:0] data;
    } cvlim_cmd_t;

    typedef struct packed {
        logic [15:0] vout;
        logic [15:0] iout;
        logic [15:0] temp;
    } cvlim_tele_t;

endpackage : cvlim_pkg

// File: verilog/cvlim_regs.sv
// module: percent-limit select, power-good hysteresis and options register bank
// Operation
// R1 - loop follower: limit select writes ignored, access refused, command fault and alert
// R2 - codes 00 and 01 give 83/88/112/117 and 88/90/110/112 percent
// R3 - codes 10 and 11 give 72/78 and 58/64 under, 112/117 over
// R4 - power-good drops above overvoltage warning or below undervoltage warning
// R5 - power-good returns below 105% after over, above 95% after under
// R6 - store-all command copies options into nonvolatile image
// R7 - negative-limit-disable bit turns off low-side negative current limit
// R8 - pin-function bit 0 gives power-good, 1 gives active-low reset
// R9 - monitor converter runs only while enable bit is 1; resets to 1
// R10 - enable bit 0 freezes voltage, current and temperature readbacks
// R11 - fast mode: voltage only, faster; bit is never stored
// R12 - first average after mode change may miss one sample, divided by full count
// R13 - override bit skips data checks on listed registers; never stored
// R14 - under override, bad writes set no invalid flag and no alert
// R15 - clearing override raises no alert for values already held
// R16 - under limits flag below, over limits flag above, against feedback
`timescale 1ns/1ps
module cvlim_regs (
    // clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    reset_in,
    // configuration straps and nonvolatile image
    input  wire logic                    loop_follower_in,
    input  wire logic [15:0]             nvm_options_in,
    input  wire logic                    nvm_valid_in,
    // command port from the bus engine
    input  cvlim_pkg::cvlim_cmd_t        cmd_in,
    input  wire logic                    cmd_checked_in,
    input  wire logic                    cmd_data_bad_in,
    output logic                         cmd_nack_out,
    output logic [15:0]                  read_data_out,
    output logic                         invalid_command_fault_out,
    output logic                         invalid_value_flag_out,
    output logic                         alert_out,
    // monitoring path
    input  wire logic [7:0]              feedback_node_in,
    input  cvlim_pkg::cvlim_tele_t       sample_in,
    input  wire logic                    sample_valid_in,
    output cvlim_pkg::cvlim_tele_t       readback_out,
    output logic                         monitor_converter_run_out,
    output logic                         sample_tick_out,
    // protection and pin
    output logic                         negative_limit_disable_out,
    output logic                         power_good_out,
    output logic                         shared_reset_good_pin_n_out,
    output logic [3:0]                   flag_out,
    // nonvolatile store
    output logic [15:0]                  nvm_store_data_out,
    output logic                         nvm_store_strobe_out
);
    import cvlim_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]        pct_reg,   pct_next;
    logic [15:0]       opt_reg,   opt_next;
    logic              nvm_done_reg, nvm_done_next;
    logic              nack_reg,  nack_next;
    logic [15:0]       rdata_reg, rdata_next;
    logic              ivc_reg,   ivc_next;
    logic              ivd_reg,   ivd_next;
    logic              alert_reg, alert_next;
    logic [15:0]       st_data_reg, st_data_next;
    logic              st_strb_reg, st_strb_next;
    cvlim_thresh_t     thresh;

    // ------------------------------------------------------------
    // threshold lookup
    // ------------------------------------------------------------
    cvlim_thresh_table u_table (
        .clk_in     (clk_in),
        .reset_in   (reset_in),
        .select_in  (pct_reg[1:0]),
        .thresh_out (thresh)
    );

    // ------------------------------------------------------------
    // command decode and register writes
    // ------------------------------------------------------------
    always_comb begin
        pct_next      = pct_reg;
        opt_next      = opt_reg;
        nvm_done_next = nvm_done_reg | nvm_valid_in;
        nack_next     = 1'b0;
        rdata_next    = rdata_reg;
        ivc_next      = ivc_reg;
        ivd_next      = ivd_reg;
        alert_next    = alert_reg;
        st_data_next  = st_data_reg;
        st_strb_next  = 1'b0;
        // restore stored options once after reset; volatile bits keep reset value
        if (!nvm_done_reg && nvm_valid_in) begin
            opt_next = (nvm_options_in & CVLIM_OPT_NVM_MASK)
                     | (CVLIM_OPT_RESET & ~CVLIM_OPT_NVM_MASK);
        end
        if (cmd_in.write || cmd_in.read) begin
            unique case (cmd_in.code)
                CVLIM_CMD_PCT_SELECT: begin
                    if (loop_follower_in) begin
                        nack_next  = 1'b1;             // see R1
                        ivc_next   = 1'b1;             // see R1
                        alert_next = 1'b1;             // see R1
                    end else if (cmd_in.write) begin
                        pct_next = cmd_in.data[7:0] & CVLIM_PCT_WMASK;
                    end else begin
                        rdata_next = {8'h00, pct_reg};
                    end
                end
                CVLIM_CMD_OPTIONS: begin
                    if (cmd_in.write) begin
                        opt_next = cmd_in.data & CVLIM_OPT_WMASK;
                    end else begin
                        rdata_next = opt_reg;
                    end
                end
                CVLIM_CMD_STORE_ALL: begin
                    if (cmd_in.write) begin
                        st_data_next = opt_reg & CVLIM_OPT_NVM_MASK; // see R6 R11 R13
                        st_strb_next = 1'b1;                         // see R6
                    end
                end
                default: begin
                    // other commands handled elsewhere; data checks below
                end
            endcase
        end
        // a bad write to a checked register flags only without override;
        // leaving override later never re-raises anything (no sweep)
        if (cmd_in.write && cmd_checked_in && cmd_data_bad_in
            && !opt_reg[CVLIM_OPT_LIMIT_OVR]) begin               // see R13 R14 R15
            ivd_next   = 1'b1;
            alert_next = 1'b1;
        end
    end

    // register the command state
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pct_reg      <= CVLIM_PCT_RESET;
            opt_reg      <= CVLIM_OPT_RESET;                       // see R9
            nvm_done_reg <= 1'b0;
            nack_reg     <= 1'b0;
            rdata_reg    <= 16'h0000;
            ivc_reg      <= 1'b0;
            ivd_reg      <= 1'b0;
            alert_reg    <= 1'b0;
            st_data_reg  <= 16'h0000;
            st_strb_reg  <= 1'b0;
        end else begin
            pct_reg      <= pct_next;
            opt_reg      <= opt_next;
            nvm_done_reg <= nvm_done_next;
            nack_reg     <= nack_next;
            rdata_reg    <= rdata_next;
            ivc_reg      <= ivc_next;
            ivd_reg      <= ivd_next;
            alert_reg    <= alert_next;
            st_data_reg  <= st_data_next;
            st_strb_reg  <= st_strb_next;
        end
    end

    // ------------------------------------------------------------
    // threshold comparison and power-good hysteresis
    // ------------------------------------------------------------
    logic       pg_reg,   pg_next;
    logic       ovt_reg,  ovt_next;
    logic       uvt_reg,  uvt_next;
    logic [3:0] flag_reg, flag_next;
    logic       pin_reg,  pin_next;
    logic       nl_reg,   nl_next;

    always_comb begin
        ovt_next = ovt_reg;
        uvt_next = uvt_reg;
        // under flags below, over flags above
        flag_next = {feedback_node_in > thresh.ov_fault,
                     feedback_node_in > thresh.ov_warn,
                     feedback_node_in < thresh.uv_warn,
                     feedback_node_in < thresh.uv_fault};          // see R16
        if (feedback_node_in > thresh.ov_warn) begin
            ovt_next = 1'b1;                                       // see R4
        end else if (feedback_node_in < CVLIM_PG_OV_RELEASE) begin
            ovt_next = 1'b0;                                       // see R5
        end
        if (feedback_node_in < thresh.uv_warn) begin
            uvt_next = 1'b1;                                       // see R4
        end else if (feedback_node_in > CVLIM_PG_UV_RELEASE) begin
            uvt_next = 1'b0;                                       // see R5
        end
        pg_next  = !ovt_next && !uvt_next;
        // pin function: level of power-good, or reset held low while not good
        pin_next = pg_next;                                        // see R8
        nl_next  = opt_reg[CVLIM_OPT_NEG_LIMIT_DIS];               // see R7
    end

    // register the comparison state
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ovt_reg  <= 1'b0;
            uvt_reg  <= 1'b1;
            pg_reg   <= 1'b0;
            flag_reg <= 4'h0;
            pin_reg  <= 1'b0;
            nl_reg   <= 1'b0;
        end else begin
            ovt_reg  <= ovt_next;
            uvt_reg  <= uvt_next;
            pg_reg   <= pg_next;
            flag_reg <= flag_next;
            pin_reg  <= pin_next;
            nl_reg   <= nl_next;
        end
    end

    // ------------------------------------------------------------
    // monitoring converter pacing and readback update
    // ------------------------------------------------------------
    logic [$clog2(CVLIM_SAMPLE_CYC)-1:0] div_reg, div_next;
    logic        tick_reg, tick_next;
    logic        run_reg,  run_next;
    cvlim_tele_t rb_reg,   rb_next;
    logic        fast;
    logic        run;

    assign fast = opt_reg[CVLIM_OPT_FAST_MEASURE];
    assign run  = opt_reg[CVLIM_OPT_MON_ENABLE];

    // fast mode paces samples four times quicker; the averager
    // upstream may lose one sample at the switch (known 1/8 error)
    always_comb begin
        run_next  = run;                                           // see R9
        tick_next = 1'b0;
        div_next  = div_reg;
        rb_next   = rb_reg;
        if (run) begin
            if ((fast && div_reg >= ($bits(div_reg))'(CVLIM_SAMPLE_CYC / 4 - 1))
                || div_reg == ($bits(div_reg))'(CVLIM_SAMPLE_CYC - 1)) begin
                div_next  = '0;
                tick_next = 1'b1;                                  // see R11 R12
            end else begin
                div_next = div_reg + 1'b1;
            end
            if (sample_valid_in) begin
                rb_next.vout = sample_in.vout;
                if (!fast) begin
                    rb_next.iout = sample_in.iout;                 // see R11
                    rb_next.temp = sample_in.temp;
                end
            end
        end
        // disabled: readbacks simply hold                       see R10
    end

    // register the monitor state
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            div_reg  <= '0;
            tick_reg <= 1'b0;
            run_reg  <= 1'b1;
            rb_reg   <= '0;
        end else begin
            div_reg  <= div_next;
            tick_reg <= tick_next;
            run_reg  <= run_next;
            rb_reg   <= rb_next;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------
    assign cmd_nack_out                = nack_reg;
    assign read_data_out               = rdata_reg;
    assign invalid_command_fault_out   = ivc_reg;
    assign invalid_value_flag_out      = ivd_reg;
    assign alert_out                   = alert_reg;
    assign readback_out                = rb_reg;
    assign monitor_converter_run_out   = run_reg;
    assign sample_tick_out             = tick_reg;
    assign negative_limit_disable_out  = nl_reg;
    assign power_good_out              = pg_reg;
    assign shared_reset_good_pin_n_out = pin_reg;
    assign flag_out                    = flag_reg;
    assign nvm_store_data_out          = st_data_reg;
    assign nvm_store_strobe_out        = st_strb_reg;

endmodule : cvlim_regs

// File: verilog/cvlim_thresh_table.sv
// module: percent threshold lookup for the four select codes
`timescale 1ns/1ps
module cvlim_thresh_table (
    // clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    reset_in,
    // select and result
    input  wire logic [1:0]              select_in,
    output cvlim_pkg::cvlim_thresh_t     thresh_out
);
    import cvlim_pkg::*;

    cvlim_thresh_t thresh_reg;
    cvlim_thresh_t thresh_next;

    // ------------------------------------------------------------
    // table, percent of reference
    // ------------------------------------------------------------
    always_comb begin
        unique case (select_in)
            2'b00:   thresh_next = '{8'd83, 8'd88, 8'd112, 8'd117}; // see R2
            2'b01:   thresh_next = '{8'd88, 8'd90, 8'd110, 8'd112}; // see R2
            2'b10:   thresh_next = '{8'd72, 8'd78, 8'd112, 8'd117}; // see R3
            2'b11:   thresh_next = '{8'd58, 8'd64, 8'd112, 8'd117}; // see R3
        endcase
    end

    // registered so the comparators see a clean value
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            thresh_reg <= '{8'd83, 8'd88, 8'd112, 8'd117};
        end else begin
            thresh_reg <= thresh_next;
        end
    end

    assign thresh_out = thresh_reg;

endmodule : cvlim_thresh_table
